// ---- ssp_alu.sv ----
`timescale 1ns/100ps
`include "ssp_defs.svh"


// ============================================================
// Top of the saturating and packing datapath.
// ============================================================
module ssp_alu
    import ssp_pkg::*;
(
    input wire logic clk, // Core clock.
    input wire logic resetn, // Synchronous reset, active low.
    input wire logic ce, // Clock enable; low freezes state.
    input wire logic issue, // Decoder presents an operation.
    input wire ssp_op_t op, // Operation select.
    input wire logic cond_pass, // Condition code evaluated true.
    input wire logic [31:0] opnd_a, // First operand.
    input wire logic [31:0] opnd_b, // Second operand.
    input wire logic [4:0] shift_amt, // Encoded pack shift.
    input wire logic [3:0] dest_in, // Destination register number.
    input wire logic nzcv_in, // Condition flags carried from core, unused here.
    input wire logic q_clear, // Explicit status register write clearing the flag.
    output logic [31:0] result_q, // Result word.
    output logic [3:0] dest_q, // Destination register number.
    output logic wr_en_q, // Register file write strobe, one cycle.
    output logic sat_q, // Doubling clamp occurred in this operation, one cycle.
    output logic q_flag_q // Sticky saturation flag.
);

    // ============================================================
    // Doubling arithmetic.
    // ============================================================

    // Signed 32-bit clamp of a 33-bit value, returning a clamp indication.
    function automatic logic [32:0] sat_s32(input logic [32:0] v);
        if (v[32] != v[31]) begin
            sat_s32 = {1'b1, v[32] ? `SSP_S32_MIN : `SSP_S32_MAX};
        end else begin
            sat_s32 = {1'b0, v[31:0]};
        end
    endfunction

    ssp_state_t state_q; // Result stage state.
    logic [32:0] dbl_raw; // Second operand times two, widened.
    logic [32:0] dbl_s; // Clamped double with clamp bit.
    logic [32:0] sum_raw; // Sum or difference, widened.
    logic [32:0] sum_s; // Clamped sum with clamp bit.
    logic is_dbl; // Doubling operation selected.
    logic dbl_sub; // Doubling subtract selected.
    logic is_pack; // Packing operation selected.
    logic [31:0] lane_res; // Lane unit result.
    logic [31:0] pack_res; // Packing unit result.
    logic [31:0] res_d; // Selected result.
    logic sat_d; // Doubling clamp seen in this operation.
    logic do_op; // Operation executes.

    assign is_dbl = (op == SSP_DOUBLE_SAT_ADD_OP) || (op == SSP_DOUBLE_SAT_SUB_OP);
    assign dbl_sub = (op == SSP_DOUBLE_SAT_SUB_OP);
    assign is_pack = (op == SSP_PACK_BOTTOM_TOP_OP) || (op == SSP_PACK_TOP_BOTTOM_OP);
    // double clamped on its own.
    // A plain shift keeps the sign in bit 32, so the clamp sees the true double.
    assign dbl_raw = {opnd_b, 1'b0};
    assign dbl_s = sat_s32(dbl_raw);
    // add or subtract the clamped double.
    assign sum_raw = dbl_sub ? ({opnd_a[31], opnd_a} - {dbl_s[31], dbl_s[31:0]})
                             : ({opnd_a[31], opnd_a} + {dbl_s[31], dbl_s[31:0]});
    assign sum_s = sat_s32(sum_raw);
    assign do_op = issue && cond_pass && (op != SSP_NOP);

    // ============================================================
    // Sub-units.
    // ============================================================

    ssp_lanes u_lanes (
        .op(op),
        .a(opnd_a),
        .b(opnd_b),
        .res(lane_res)
    );

    ssp_pack u_pack (
        .top_bottom(op == SSP_PACK_TOP_BOTTOM_OP),
        .a(opnd_a),
        .b(opnd_b),
        .sh(shift_amt),
        .res(pack_res)
    );

    // Result and clamp selection.
    always_comb begin
        if (is_dbl) begin
            res_d = sum_s[31:0];
            sat_d = dbl_s[32] || sum_s[32];
        end else if (is_pack) begin
            res_d = pack_res;
            sat_d = 1'b0;
        end else begin
            res_d = lane_res;
            sat_d = 1'b0;
        end
    end

    // ============================================================
    // Result stage.
    // ============================================================

    // Result register and write strobe.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            result_q <= `SSP_RES_RST;
            dest_q <= 4'h0;
            wr_en_q <= 1'b0;
            sat_q <= 1'b0;
        end else if (ce) begin
            wr_en_q <= do_op;
            sat_q <= do_op && sat_d;
            if (do_op) begin
                result_q <= res_d;
                dest_q <= dest_in;
            end
        end
    end

    // Result stage state: DONE for each cycle that carries a write-back.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q <= SSP_IDLE;
        end else if (ce) begin
            case (state_q)
                // An executed operation opens a write-back cycle.
                SSP_IDLE: begin
                    state_q <= do_op ? SSP_DONE : SSP_IDLE;
                end
                // Back-to-back operations keep the stage writing back.
                SSP_DONE: begin
                    state_q <= do_op ? SSP_DONE : SSP_IDLE;
                end
                // Unused codes fall back to idle.
                default: begin
                    state_q <= SSP_IDLE;
                end
            endcase
        end
    end

    // Sticky saturation flag.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            q_flag_q <= `SSP_Q_RST;
        end else if (ce) begin
            if (do_op && sat_d) begin
                q_flag_q <= 1'b1;
            end else if (q_clear) begin
                q_flag_q <= 1'b0;
            end
        end
    end

    // ============================================================
    // Assertions.
    // ============================================================

    // A clamped double of the largest word added to a negative word stays in range.
    property p_dbl_add;
        @(posedge clk) disable iff (!resetn)
        (ce && do_op && op == SSP_DOUBLE_SAT_ADD_OP && opnd_b == `SSP_S32_MAX) |=>
        (result_q == (($past(opnd_a[31])) ? `SSP_S32_MAX + $past(opnd_a) : `SSP_S32_MAX));
    endproperty
    a_dbl_add: assert property (p_dbl_add) else $error("doubling add of max not clamped");

    property p_dbl_sub_min;
        @(posedge clk) disable iff (!resetn)
        (ce && do_op && op == SSP_DOUBLE_SAT_SUB_OP && opnd_a == `SSP_S32_MIN && !opnd_b[31] && opnd_b != 32'h0)
        |=> (result_q == `SSP_S32_MIN && sat_q);
    endproperty
    a_dbl_sub_min: assert property (p_dbl_sub_min) else $error("doubling subtract not clamped low");

    // Top two bits differing means the double leaves the signed range.
    property p_dbl_step;
        @(posedge clk) disable iff (!resetn)
        (ce && do_op && is_dbl && (opnd_b[31] != opnd_b[30])) |=> (sat_q && q_flag_q);
    endproperty
    a_dbl_step: assert property (p_dbl_step) else $error("doubling clamp not flagged");

    property p_q_sticky;
        @(posedge clk) disable iff (!resetn)
        (q_flag_q && !q_clear) |=> q_flag_q;
    endproperty
    a_q_sticky: assert property (p_q_sticky) else $error("sticky flag dropped without write");

    property p_q_set;
        @(posedge clk) disable iff (!resetn)
        sat_q |-> q_flag_q;
    endproperty
    a_q_set: assert property (p_q_set) else $error("clamp did not set sticky flag");

    property p_lane_noflag;
        @(posedge clk) disable iff (!resetn)
        (ce && do_op && !is_dbl) |=> !sat_q;
    endproperty
    a_lane_noflag: assert property (p_lane_noflag) else $error("non-doubling op flagged");

    property p_u8_add;
        @(posedge clk) disable iff (!resetn)
        (ce && do_op && op == SSP_UNSIGNED_QUAD_BYTE_SAT_ADD_OP && opnd_a[7:0] == `SSP_U8_MAX)
        |=> (result_q[7:0] == `SSP_U8_MAX);
    endproperty
    a_u8_add: assert property (p_u8_add) else $error("byte add not clamped");

    property p_u16_sub;
        @(posedge clk) disable iff (!resetn)
        (ce && do_op && op == SSP_UNSIGNED_DUAL_HALF_SAT_SUB_OP && opnd_a[15:0] < opnd_b[15:0])
        |=> (result_q[15:0] == 16'h0000);
    endproperty
    a_u16_sub: assert property (p_u16_sub) else $error("halfword subtract not clamped to zero");

    property p_pack_tb;
        @(posedge clk) disable iff (!resetn)
        (ce && do_op && op == SSP_PACK_TOP_BOTTOM_OP && shift_amt == `SSP_SH_ZERO)
        |=> (result_q[15:0] == {16{$past(opnd_b[31])}} && result_q[31:16] == $past(opnd_a[31:16]));
    endproperty
    a_pack_tb: assert property (p_pack_tb) else $error("zero right shift not taken as 32");

    property p_no_cond;
        @(posedge clk) disable iff (!resetn)
        (ce && issue && !cond_pass) |=> (!wr_en_q && $stable(result_q) && !$rose(q_flag_q));
    endproperty
    a_no_cond: assert property (p_no_cond) else $error("failed condition changed state");

    // Unshifted bottom-top packing keeps the second operand's top half.
    property p_pack_bt_zero;
        @(posedge clk) disable iff (!resetn)
        (ce && do_op && op == SSP_PACK_BOTTOM_TOP_OP && shift_amt == `SSP_SH_ZERO)
        |=> (result_q == {$past(opnd_b[31:16]), $past(opnd_a[15:0])});
    endproperty
    a_pack_bt_zero: assert property (p_pack_bt_zero) else $error("zero left shift altered operand");

    // A clear with no new clamp empties the sticky flag.
    property p_q_clear;
        @(posedge clk) disable iff (!resetn)
        (ce && q_clear && !(do_op && sat_d)) |=> !q_flag_q;
    endproperty
    a_q_clear: assert property (p_q_clear) else $error("sticky flag not cleared by write");

    // A low clock enable holds the result, strobe, destination and sticky flag.
    property p_freeze;
        @(posedge clk) disable iff (!resetn)
        !ce |=> ($stable(result_q) && $stable(wr_en_q) && $stable(q_flag_q) && $stable(dest_q));
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

    // Signed exchange top lane clamps high on a positive overflow.
    property p_s16_hi;
        @(posedge clk) disable iff (!resetn)
        (ce && do_op && op == SSP_SIGNED_ADD_SUB_EXCHANGE_OP && opnd_a[31:16] == `SSP_S16_MAX && !opnd_b[15]
         && opnd_b[15:0] != 16'h0000) |=> (result_q[31:16] == `SSP_S16_MAX);
    endproperty
    a_s16_hi: assert property (p_s16_hi) else $error("signed top lane not clamped high");

    // The write-back cycle of the stage always carries the strobe.
    property p_done_wr;
        @(posedge clk) disable iff (!resetn)
        (state_q == SSP_DONE) |-> wr_en_q;
    endproperty
    a_done_wr: assert property (p_done_wr) else $error("write-back cycle without strobe");

    c_dbl_sat: cover property (@(posedge clk) disable iff (!resetn) sat_q);
    c_q_clear: cover property (@(posedge clk) disable iff (!resetn) $fell(q_flag_q));
    c_pack: cover property (@(posedge clk) disable iff (!resetn) ce && do_op && is_pack);
    c_skip: cover property (@(posedge clk) disable iff (!resetn) ce && issue && !cond_pass);
    c_set_clear: cover property (@(posedge clk) disable iff (!resetn) ce && q_clear && do_op && sat_d);

endmodule // ssp_alu

// ---- ssp_defs.svh ----
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH

// Data widths.
`define SSP_WORD_W 32
`define SSP_HALF_W 16
`define SSP_BYTE_W 8
// Signed 32-bit range limits.
`define SSP_S32_MAX 32'h7FFFFFFF
`define SSP_S32_MIN 32'h80000000
// Signed 16-bit range limits.
`define SSP_S16_MAX 16'h7FFF
`define SSP_S16_MIN 16'h8000
// Unsigned lane limits.
`define SSP_U16_MAX 16'hFFFF
`define SSP_U8_MAX 8'hFF
// Shift field width and the full right shift that an all-zero field means.
`define SSP_SH_W 5
`define SSP_SH_ZERO 5'h00
`define SSP_ASR_FULL 6'h20
// Reset values.
`define SSP_RES_RST 32'h00000000
`define SSP_Q_RST 1'b0

`endif

// ---- ssp_lanes.sv ----
`timescale 1ns/100ps
`include "ssp_defs.svh"

// ============================================================
// Halfword and byte lane saturating arithmetic.
// ============================================================
module ssp_lanes
    import ssp_pkg::*;
(
    input wire ssp_op_t op, // Selected operation.
    input wire logic [31:0] a, // First operand.
    input wire logic [31:0] b, // Second operand.
    output logic [31:0] res // Lane result.
);

    // Signed 16-bit clamp of a 17-bit value.
    function automatic logic [15:0] sat_s16(input logic [16:0] v);
        if (v[16] != v[15]) begin
            sat_s16 = v[16] ? `SSP_S16_MIN : `SSP_S16_MAX;
        end else begin
            sat_s16 = v[15:0];
        end
    endfunction

    // Unsigned 16-bit add or subtract with clamp.
    function automatic logic [15:0] sat_u16(input logic [15:0] x, input logic [15:0] y, input logic sub);
        logic [16:0] t;
        t = sub ? ({1'b0, x} - {1'b0, y}) : ({1'b0, x} + {1'b0, y});
        if (t[16]) begin
            sat_u16 = sub ? 16'h0000 : `SSP_U16_MAX;
        end else begin
            sat_u16 = t[15:0];
        end
    endfunction

    // Unsigned 8-bit add or subtract with clamp.
    function automatic logic [7:0] sat_u8(input logic [7:0] x, input logic [7:0] y, input logic sub);
        logic [8:0] t;
        t = sub ? ({1'b0, x} - {1'b0, y}) : ({1'b0, x} + {1'b0, y});
        if (t[8]) begin
            sat_u8 = sub ? 8'h00 : `SSP_U8_MAX;
        end else begin
            sat_u8 = t[7:0];
        end
    endfunction

    logic [16:0] s_hi_add; // Signed top plus bottom.
    logic [16:0] s_lo_sub; // Signed bottom minus top.
    logic [16:0] s_hi_sub; // Signed top minus bottom.
    logic [16:0] s_lo_add; // Signed bottom plus top.
    logic quad_sub; // Byte lanes subtract.

    assign s_hi_add = {a[31], a[31:16]} + {b[15], b[15:0]};
    assign s_lo_sub = {a[15], a[15:0]} - {b[31], b[31:16]};
    assign s_hi_sub = {a[31], a[31:16]} - {b[15], b[15:0]};
    assign s_lo_add = {a[15], a[15:0]} + {b[31], b[31:16]};
    assign quad_sub = (op == SSP_UNSIGNED_QUAD_BYTE_SAT_SUB_OP);

    // Lane result selection.
    always_comb begin
        case (op)
            SSP_SIGNED_ADD_SUB_EXCHANGE_OP: begin
                res = {sat_s16(s_hi_add), sat_s16(s_lo_sub)};
            end
            SSP_SIGNED_SUB_ADD_EXCHANGE_OP: begin
                res = {sat_s16(s_hi_sub), sat_s16(s_lo_add)};
            end
            SSP_UNSIGNED_ADD_SUB_EXCHANGE_OP: begin
                res = {sat_u16(a[31:16], b[15:0], 1'b0), sat_u16(a[15:0], b[31:16], 1'b1)};
            end
            SSP_UNSIGNED_SUB_ADD_EXCHANGE_OP: begin
                res = {sat_u16(a[31:16], b[15:0], 1'b1), sat_u16(a[15:0], b[31:16], 1'b0)};
            end
            SSP_UNSIGNED_DUAL_HALF_SAT_ADD_OP: begin
                res = {sat_u16(a[31:16], b[31:16], 1'b0), sat_u16(a[15:0], b[15:0], 1'b0)};
            end
            SSP_UNSIGNED_DUAL_HALF_SAT_SUB_OP: begin
                res = {sat_u16(a[31:16], b[31:16], 1'b1), sat_u16(a[15:0], b[15:0], 1'b1)};
            end
            SSP_UNSIGNED_QUAD_BYTE_SAT_ADD_OP, SSP_UNSIGNED_QUAD_BYTE_SAT_SUB_OP: begin
                res = {sat_u8(a[31:24], b[31:24], quad_sub), sat_u8(a[23:16], b[23:16], quad_sub),
                       sat_u8(a[15:8], b[15:8], quad_sub), sat_u8(a[7:0], b[7:0], quad_sub)};
            end
            // Other operations are handled elsewhere.
            default: begin
                res = `SSP_RES_RST;
            end
        endcase
    end

endmodule // ssp_lanes

// ---- ssp_pack.sv ----
`timescale 1ns/100ps
`include "ssp_defs.svh"

// ============================================================
// Halfword packing with shift.
// ============================================================
module ssp_pack
    import ssp_pkg::*;
(
    input wire logic top_bottom, // High selects top-bottom packing.
    input wire logic [31:0] a, // First operand.
    input wire logic [31:0] b, // Second operand.
    input wire logic [4:0] sh, // Encoded shift amount.
    output logic [31:0] res // Packed result.
);

    logic [31:0] lsl_val; // Left-shifted second operand.
    logic [5:0] asr_amt; // Decoded right shift, 1 to 32.
    logic signed [31:0] asr_val; // Right-shifted second operand.

    assign lsl_val = b << sh;
    assign asr_amt = (sh == `SSP_SH_ZERO) ? `SSP_ASR_FULL : {1'b0, sh};
    assign asr_val = $signed(b) >>> asr_amt;

    // Result assembly.
    always_comb begin
        if (top_bottom) begin
            res = {a[31:16], asr_val[15:0]};
        end else begin
            res = {lsl_val[31:16], a[15:0]};
        end
    end

endmodule // ssp_pack

// ---- ssp_pkg.sv ----
package ssp_pkg;

    // Operation selects driven by the instruction decoder.
    typedef enum logic [3:0] {
        SSP_NOP,
        SSP_DOUBLE_SAT_ADD_OP,
        SSP_DOUBLE_SAT_SUB_OP,
        SSP_SIGNED_ADD_SUB_EXCHANGE_OP,
        SSP_SIGNED_SUB_ADD_EXCHANGE_OP,
        SSP_UNSIGNED_ADD_SUB_EXCHANGE_OP,
        SSP_UNSIGNED_SUB_ADD_EXCHANGE_OP,
        SSP_UNSIGNED_DUAL_HALF_SAT_ADD_OP,
        SSP_UNSIGNED_QUAD_BYTE_SAT_ADD_OP,
        SSP_UNSIGNED_DUAL_HALF_SAT_SUB_OP,
        SSP_UNSIGNED_QUAD_BYTE_SAT_SUB_OP,
        SSP_PACK_BOTTOM_TOP_OP,
        SSP_PACK_TOP_BOTTOM_OP
    } ssp_op_t;

    // Result stage states.
    typedef enum logic [1:0] {
        SSP_IDLE,
        SSP_DONE
    } ssp_state_t;

endpackage

// ---- ssp_regfile_model.sv ----
`timescale 1ns/100ps

// ==========
// Register file model that takes the datapath's write-backs.
// ==========
module ssp_regfile_model (
    input wire logic clk, // Core clock.
    input wire logic resetn, // Synchronous reset, active low.
    input wire logic wr_en, // Write strobe from the datapath.
    input wire logic [3:0] dest, // Destination register number.
    input wire logic [31:0] data // Result word.
);
    logic [31:0] regs_q [16]; // Architectural registers.

    // A write lands on the edge that samples the one-cycle strobe.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            for (int i = 0; i < 16; i++) begin
                regs_q[i] <= 32'h00000000;
            end
        end else if (wr_en) begin
            regs_q[dest] <= data;
        end
    end
endmodule // ssp_regfile_model

// ---- tb_saturating_simd_pack_alu.sv ----
`timescale 1ns/100ps
`include "ssp_defs.svh"

// ==========
// Self-checking bench for the saturating and packing datapath.
// ==========
module tb_saturating_simd_pack_alu
    import ssp_pkg::*;
;
    localparam longint S32_MAX = 64'sh000000007FFFFFFF; // Largest signed word.
    localparam longint S32_MIN = 64'shFFFFFFFF80000000; // Smallest signed word.
    logic clk = 1'b0, resetn = 1'b0, ce = 1'b1, issue = 1'b0, cond_pass = 1'b1, q_clear = 1'b0;
    ssp_op_t op = SSP_NOP; // Operation select.
    logic [31:0] opnd_a = 32'h00000000, opnd_b = 32'h00000000; // Operands.
    logic [4:0] shift_amt = 5'h00; // Pack shift field.
    logic [3:0] dest_in = 4'h0; // Destination number, stepped by each run_op call.
    logic [31:0] result_q; // Result word.
    logic [3:0] dest_q; // Registered destination.
    logic wr_en_q, sat_q, q_flag_q; // Strobe, clamp pulse and sticky flag.
    int err_total = 0, checks_done = 0, cycles = 0; // Counters.
    logic q_exp = 1'b0; // Expected sticky flag.

    ssp_alu u_dut (.clk(clk), .resetn(resetn), .ce(ce), .issue(issue), .op(op), .cond_pass(cond_pass),
        .opnd_a(opnd_a), .opnd_b(opnd_b), .shift_amt(shift_amt), .dest_in(dest_in), .nzcv_in(1'b0),
        .q_clear(q_clear), .result_q(result_q), .dest_q(dest_q), .wr_en_q(wr_en_q), .sat_q(sat_q),
        .q_flag_q(q_flag_q));
    ssp_regfile_model u_rf (.clk(clk), .resetn(resetn), .wr_en(wr_en_q), .dest(dest_q), .data(result_q));

    // The clock toggles every 12.5 ns, half of its 25 ns period.
    initial begin
        forever #12.5 clk = ~clk;
    end

    // A hang is cut short after a ceiling well above the planned run.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            stop_test();
        end
    end

    // Compares a seen value with the expected one and counts it.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Clamps a value to a range and notes whether it clamped.
    function automatic longint clamp(longint x, longint lo, longint hi, inout logic s);
        if (x > hi) begin
            s = 1'b1;
            return hi;
        end
        if (x < lo) begin
            s = 1'b1;
            return lo;
        end
        return x;
    endfunction

    // Reference result; bit 32 tells whether a doubling step clamped.
    function automatic logic [32:0] model(ssp_op_t o, logic [31:0] a, logic [31:0] b, logic [4:0] sh);
        longint d, ah, al, bh, bl, uah, ual, ubh, ubl;
        logic s, l;
        logic [31:0] v;
        logic [63:0] t;
        s = 1'b0;
        l = 1'b0;
        v = 32'h00000000;
        ah = $signed(a[31:16]);
        al = $signed(a[15:0]);
        bh = $signed(b[31:16]);
        bl = $signed(b[15:0]);
        uah = a[31:16];
        ual = a[15:0];
        ubh = b[31:16];
        ubl = b[15:0];
        d = clamp(2 * longint'($signed(b)), S32_MIN, S32_MAX, s);
        case (o)
            SSP_DOUBLE_SAT_ADD_OP: v = 32'(clamp(longint'($signed(a)) + d, S32_MIN, S32_MAX, s));
            SSP_DOUBLE_SAT_SUB_OP: v = 32'(clamp(longint'($signed(a)) - d, S32_MIN, S32_MAX, s));
            SSP_SIGNED_ADD_SUB_EXCHANGE_OP: v = {16'(clamp(ah + bl, -32768, 32767, l)), 16'(clamp(al - bh, -32768, 32767, l))};
            SSP_SIGNED_SUB_ADD_EXCHANGE_OP: v = {16'(clamp(ah - bl, -32768, 32767, l)), 16'(clamp(al + bh, -32768, 32767, l))};
            SSP_UNSIGNED_ADD_SUB_EXCHANGE_OP: v = {16'(clamp(uah + ubl, 0, 65535, l)), 16'(clamp(ual - ubh, 0, 65535, l))};
            SSP_UNSIGNED_SUB_ADD_EXCHANGE_OP: v = {16'(clamp(uah - ubl, 0, 65535, l)), 16'(clamp(ual + ubh, 0, 65535, l))};
            SSP_UNSIGNED_DUAL_HALF_SAT_ADD_OP: v = {16'(clamp(uah + ubh, 0, 65535, l)), 16'(clamp(ual + ubl, 0, 65535, l))};
            SSP_UNSIGNED_DUAL_HALF_SAT_SUB_OP: v = {16'(clamp(uah - ubh, 0, 65535, l)), 16'(clamp(ual - ubl, 0, 65535, l))};
            SSP_UNSIGNED_QUAD_BYTE_SAT_ADD_OP, SSP_UNSIGNED_QUAD_BYTE_SAT_SUB_OP: begin
                for (int i = 0; i < 4; i++) begin
                    d = (o == SSP_UNSIGNED_QUAD_BYTE_SAT_ADD_OP) ? longint'(b[8*i+:8]) : -longint'(b[8*i+:8]);
                    v[8*i+:8] = 8'(clamp(longint'(a[8*i+:8]) + d, 0, 255, l));
                end
            end
            SSP_PACK_BOTTOM_TOP_OP: begin
                t = {32'h00000000, b << sh};
                v = {t[31:16], a[15:0]};
            end
            SSP_PACK_TOP_BOTTOM_OP: begin
                t = longint'($signed(b)) >>> ((sh == 5'h00) ? 32 : sh);
                v = {a[31:16], t[15:0]};
            end
            default: v = 32'h00000000;
        endcase
        if (o != SSP_DOUBLE_SAT_ADD_OP && o != SSP_DOUBLE_SAT_SUB_OP) begin
            s = 1'b0;
        end
        return {s, v};
    endfunction

    // Issues one operation for one cycle; returns after the answer settles.
    task automatic run_op(input ssp_op_t o, input logic [31:0] a, input logic [31:0] b, input logic [4:0] sh,
        input logic pass);
        @(posedge clk);
        issue <= 1'b1;
        op <= o;
        opnd_a <= a;
        opnd_b <= b;
        shift_amt <= sh;
        cond_pass <= pass;
        dest_in <= dest_in + 4'h1;
        @(posedge clk);
        issue <= 1'b0;
        #1;
    endtask

    // Executes an operation and judges every output against the model.
    task automatic exec(input ssp_op_t o, input logic [31:0] a, input logic [31:0] b, input logic [4:0] sh);
        logic [32:0] e;
        e = model(o, a, b, sh);
        run_op(o, a, b, sh, 1'b1);
        q_exp = q_exp | e[32];
        check("result_q", result_q, e[31:0]);
        check("wr_en_q", {31'h0, wr_en_q}, 32'h1);
        check("dest_q", {28'h0, dest_q}, {28'h0, dest_in});
        check("sat_q", {31'h0, sat_q}, {31'h0, e[32]});
        check("q_flag_q", {31'h0, q_flag_q}, {31'h0, q_exp});
    endtask

    // Doubling add and subtract at both clamp steps and without clamping.
    task automatic t_double();
        exec(SSP_DOUBLE_SAT_ADD_OP, 32'h00000001, 32'h00000002, 5'h00);
        exec(SSP_DOUBLE_SAT_ADD_OP, 32'h80000005, 32'h7FFFFFFF, 5'h00);
        exec(SSP_DOUBLE_SAT_ADD_OP, 32'h00000000, 32'h40000000, 5'h00);
        exec(SSP_DOUBLE_SAT_ADD_OP, 32'h7FFFFFF0, 32'h00000010, 5'h00);
        exec(SSP_DOUBLE_SAT_SUB_OP, 32'h7FFFFFFF, 32'h00000001, 5'h00);
        exec(SSP_DOUBLE_SAT_SUB_OP, 32'h00000000, 32'h80000000, 5'h00);
        exec(SSP_DOUBLE_SAT_SUB_OP, 32'h80000000, 32'h00000010, 5'h00);
    endtask

    // Every lane operation on carry and borrow boundaries.
    task automatic t_lanes();
        ssp_op_t ops [8] = '{SSP_SIGNED_ADD_SUB_EXCHANGE_OP, SSP_SIGNED_SUB_ADD_EXCHANGE_OP,
            SSP_UNSIGNED_ADD_SUB_EXCHANGE_OP, SSP_UNSIGNED_SUB_ADD_EXCHANGE_OP, SSP_UNSIGNED_DUAL_HALF_SAT_ADD_OP,
            SSP_UNSIGNED_QUAD_BYTE_SAT_ADD_OP, SSP_UNSIGNED_DUAL_HALF_SAT_SUB_OP, SSP_UNSIGNED_QUAD_BYTE_SAT_SUB_OP};
        logic [31:0] av [3] = '{32'h7FFF8000, 32'h8001FFFE, 32'h12F08001};
        logic [31:0] bv [3] = '{32'h00017FFF, 32'h7FFF0003, 32'h34208002};
        for (int i = 0; i < 8; i++) begin
            for (int j = 0; j < 3; j++) begin
                exec(ops[i], av[j], bv[j], 5'h00);
            end
        end
    endtask

    // Packing with shift fields at both ends of their range.
    task automatic t_pack();
        logic [4:0] sv [5] = '{5'h00, 5'h01, 5'h0F, 5'h10, 5'h1F};
        for (int i = 0; i < 5; i++) begin
            exec(SSP_PACK_BOTTOM_TOP_OP, 32'hA5A51234, 32'h8000C3A5, sv[i]);
            exec(SSP_PACK_TOP_BOTTOM_OP, 32'h5A5AFFFF, 32'h8000C3A5, sv[i]);
        end
    endtask

    // Refused issues, the sticky clear and back-to-back issues.
    task automatic t_refuse();
        logic [31:0] held;
        exec(SSP_DOUBLE_SAT_ADD_OP, 32'h7FFFFFFF, 32'h00000001, 5'h00);
        held = result_q;
        @(posedge clk);
        #1;
        check("reg_file", u_rf.regs_q[dest_q], held);
        run_op(SSP_DOUBLE_SAT_SUB_OP, 32'h00000000, 32'h00000004, 5'h00, 1'b0);
        check("refused_wr", {31'h0, wr_en_q}, 32'h0);
        check("refused_res", result_q, held);
        @(posedge clk);
        q_clear <= 1'b1;
        exec(SSP_DOUBLE_SAT_ADD_OP, 32'h7FFFFFFF, 32'h00000001, 5'h00);
        @(posedge clk);
        q_clear <= 1'b0;
        ce <= 1'b0;
        q_exp = 1'b0;
        #1;
        check("q_cleared", {31'h0, q_flag_q}, 32'h0);
        run_op(SSP_DOUBLE_SAT_ADD_OP, 32'h7FFFFFFF, 32'h7FFFFFFF, 5'h00, 1'b1);
        check("frozen_q", {31'h0, q_flag_q}, 32'h0);
        check("frozen_wr", {31'h0, wr_en_q}, 32'h0);
        @(posedge clk);
        ce <= 1'b1;
        run_op(SSP_NOP, 32'h7FFFFFFF, 32'h7FFFFFFF, 5'h00, 1'b1);
        check("nop_wr", {31'h0, wr_en_q}, 32'h0);
        exec(SSP_UNSIGNED_QUAD_BYTE_SAT_ADD_OP, 32'h01FF01FF, 32'hFF01FF01, 5'h00);
        check("no_lane_q", {31'h0, q_flag_q}, 32'h0);
        @(posedge clk);
        issue <= 1'b1;
        op <= SSP_UNSIGNED_DUAL_HALF_SAT_ADD_OP;
        @(posedge clk);
        op <= SSP_UNSIGNED_DUAL_HALF_SAT_SUB_OP;
        #1;
        check("b2b_first", result_q, 32'(model(SSP_UNSIGNED_DUAL_HALF_SAT_ADD_OP, opnd_a, opnd_b, 5'h00)));
        @(posedge clk);
        issue <= 1'b0;
        #1;
        check("b2b_second", result_q, 32'(model(SSP_UNSIGNED_DUAL_HALF_SAT_SUB_OP, opnd_a, opnd_b, 5'h00)));
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks_done %0d err_total %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Main sequence: reset for six cycles, then each scenario in turn.
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        #1;
        check("reset_res", result_q, 32'h00000000);
        check("reset_q", {31'h0, q_flag_q}, 32'h0);
        t_double();
        t_lanes();
        t_pack();
        t_refuse();
        stop_test();
    end
endmodule // tb_saturating_simd_pack_alu
